// ---- src/ssc_pkg.sv ----
// Package for the step sequencer once-mode and sync control block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package ssc_pkg;
   localparam int SSC_STEP_W = 10;
   localparam int SSC_LOOP_W = 20;
   localparam int SSC_SEQ_W = 10;
   localparam logic [SSC_STEP_W-1:0] SSC_STEP_FIRST = 10'h001;
   localparam logic [SSC_STEP_W-1:0] SSC_STEP_MAX = 10'h3E8;
   localparam logic [SSC_LOOP_W-1:0] SSC_ONCE_DEF = 20'h0_0001;
   localparam logic [SSC_LOOP_W-1:0] SSC_LOOP_ONE = 20'h0_0001;
   localparam logic [SSC_STEP_W-1:0] SSC_SYNC_DEF = 10'h001;

   // One entry of the step table as the sequencer sees it
   typedef struct packed {
      logic [SSC_LOOP_W-1:0] loops;
      logic [SSC_SEQ_W-1:0] seq_num;
      logic jump_flag;
   } ssc_step_type;

   typedef enum logic [1:0] {
      SSC_IDLE = 2'b00,
      SSC_PLAY = 2'b01,
      SSC_HOLD = 2'b11
   } ssc_state_type;
endpackage

// ---- src/ssc_seq_ctrl.sv ----
// Step sequencer control: once-mode table repeats, per-step loops, jump hold, sync pulse.
// Assumes a step table outside that answers step_idx with step_entry in the same cycle,
// and a waveform player that pulses seq_done at the end of each sequence replay.
`timescale 1ns/1ps

// Behaviour
// - Once mode plays whole table, repeats it programmed times, then goes idle.
// - Once loop counter accepts values from one; defaults to one.
// - Once count readback shows the programmed once count, not the running table repeat count.
// - Sync pulse defaults to step one.
// - Host may place sync on steps one to one thousand; device follows it.
// - Sync stays high for the sequence of the chosen step while it plays, and drops while that step is held.
// - Sync placement readback returns the selected step number.
// - Jump flag zero advances; flag one holds step until an event arrives.
// - Each step replays its sequence for its loop count before advancing.
module ssc_seq_ctrl
   import ssc_pkg::*;
#(
   parameter int STEP_W = SSC_STEP_W
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic once_wr,
   input wire logic [SSC_LOOP_W-1:0] once_wdata,
   input wire logic sync_wr,
   input wire logic [SSC_STEP_W-1:0] sync_wdata,
   input wire logic [SSC_STEP_W-1:0] table_len,
   input wire ssc_step_type step_entry,
   input wire logic seq_done,
   input wire logic jump_event,
   output logic [SSC_STEP_W-1:0] step_idx,
   output logic [SSC_SEQ_W-1:0] seq_sel,
   output logic playing,
   output logic sync_out,
   output logic [SSC_LOOP_W-1:0] once_rdata,
   output logic [SSC_STEP_W-1:0] sync_rdata
);
   ssc_state_type state_r, state_nxt;
   logic [SSC_LOOP_W-1:0] once_cnt_r, once_cnt_nxt;
   logic [SSC_LOOP_W-1:0] rep_r, rep_nxt;
   logic [SSC_LOOP_W-1:0] step_loop_r, step_loop_nxt;
   logic [SSC_STEP_W-1:0] step_r, step_nxt;
   logic [SSC_STEP_W-1:0] sync_pos_r, sync_pos_nxt;
   logic sync_r, sync_nxt;
   logic playing_r, playing_nxt;
   logic [SSC_SEQ_W-1:0] seq_r, seq_nxt;

   // Range check shared by the sync placement write
   function automatic logic step_ok(input logic [SSC_STEP_W-1:0] s);
      return (s >= SSC_STEP_FIRST) && (s <= SSC_STEP_MAX);
   endfunction

   // Sync high while the chosen step is playing
   function automatic logic sync_on(input logic [SSC_STEP_W-1:0] s,
                                    input logic [SSC_STEP_W-1:0] p);
      return s == p;
   endfunction

   // Host settings: once count and sync placement
   always_comb
   begin
      once_cnt_nxt = once_cnt_r;
      sync_pos_nxt = sync_pos_r;
      if (once_wr && once_wdata != '0)
      begin
         once_cnt_nxt = once_wdata;
      end
      if (sync_wr && step_ok(sync_wdata))
      begin
         sync_pos_nxt = sync_wdata;
      end
   end

   // Sequencer walk through steps and table repeats
   always_comb
   begin
      state_nxt = state_r;
      rep_nxt = rep_r;
      step_loop_nxt = step_loop_r;
      step_nxt = step_r;
      seq_nxt = seq_r;
      case (state_r)
         SSC_IDLE:
         begin
            if (start)
            begin
               state_nxt = SSC_PLAY;
               step_nxt = SSC_STEP_FIRST;
               rep_nxt = SSC_LOOP_ONE;
               step_loop_nxt = SSC_LOOP_ONE;
            end
         end
         SSC_PLAY:
         begin
            seq_nxt = step_entry.seq_num;
            if (seq_done)
            begin
               if (step_loop_r < step_entry.loops)
               begin
                  step_loop_nxt = step_loop_r + SSC_LOOP_ONE;
               end
               else if (step_entry.jump_flag)
               begin
                  state_nxt = SSC_HOLD;
               end
               else if (step_r < table_len)
               begin
                  step_nxt = step_r + SSC_STEP_FIRST;
                  step_loop_nxt = SSC_LOOP_ONE;
               end
               else if (rep_r < once_cnt_r)
               begin
                  rep_nxt = rep_r + SSC_LOOP_ONE;
                  step_nxt = SSC_STEP_FIRST;
                  step_loop_nxt = SSC_LOOP_ONE;
               end
               else
               begin
                  state_nxt = SSC_IDLE;
               end
            end
         end
         SSC_HOLD:
         begin
            if (jump_event)
            begin
               state_nxt = SSC_PLAY;
               step_loop_nxt = SSC_LOOP_ONE;
               if (step_r < table_len)
               begin
                  step_nxt = step_r + SSC_STEP_FIRST;
               end
               else if (rep_r < once_cnt_r)
               begin
                  rep_nxt = rep_r + SSC_LOOP_ONE;
                  step_nxt = SSC_STEP_FIRST;
               end
               else
               begin
                  state_nxt = SSC_IDLE;
               end
            end
         end
         default:
         begin
            state_nxt = SSC_IDLE;
         end
      endcase
   end

   // Sync output and activity flag follow the next state, so both line up with step_idx
   always_comb
   begin
      sync_nxt = (state_nxt == SSC_PLAY) && sync_on(step_nxt, sync_pos_nxt);
      playing_nxt = (state_nxt != SSC_IDLE);
   end

   // Registers
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= SSC_IDLE;
         once_cnt_r <= SSC_ONCE_DEF;
         sync_pos_r <= SSC_SYNC_DEF;
         rep_r <= SSC_LOOP_ONE;
         step_loop_r <= SSC_LOOP_ONE;
         step_r <= SSC_STEP_FIRST;
         sync_r <= 1'b0;
         playing_r <= 1'b0;
         seq_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         once_cnt_r <= once_cnt_nxt;
         sync_pos_r <= sync_pos_nxt;
         rep_r <= rep_nxt;
         step_loop_r <= step_loop_nxt;
         step_r <= step_nxt;
         sync_r <= sync_nxt;
         playing_r <= playing_nxt;
         seq_r <= seq_nxt;
      end
   end

   assign step_idx = step_r;
   assign seq_sel = seq_r;
   assign playing = playing_r;
   assign sync_out = sync_r;
   assign once_rdata = once_cnt_r;
   assign sync_rdata = sync_pos_r;

   // Assertions: sync placement and width
   a_sync_on_step: assert property (@(posedge clock) disable iff (srst)
      sync_out |-> (step_idx == sync_rdata) && state_r == SSC_PLAY)
      else $error("sync high off its step");
   a_sync_covers: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_PLAY && step_idx == sync_rdata |-> sync_out)
      else $error("sync low on its step");
   a_idle_no_sync: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_IDLE |-> !sync_out)
      else $error("sync high while idle");
   a_idle_stays: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_IDLE && !start |=> !playing && !sync_out)
      else $error("left idle without start");
   // Host settings and their readback
   a_once_nonzero: assert property (@(posedge clock) disable iff (srst)
      once_rdata != '0)
      else $error("once count zero");
   a_sync_range: assert property (@(posedge clock) disable iff (srst)
      sync_wr && step_ok(sync_wdata) |=> sync_rdata == $past(sync_wdata))
      else $error("sync placement not taken");
   a_once_write: assert property (@(posedge clock) disable iff (srst)
      once_wr && once_wdata != '0 |=> once_rdata == $past(once_wdata))
      else $error("once count not taken");
   // Step walk: start, hold, release, loops and repeats
   a_start_first: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_IDLE && start |=> playing && step_idx == SSC_STEP_FIRST)
      else $error("start did not enter first step");
   a_hold_wait: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_HOLD && !jump_event |=> state_r == SSC_HOLD && $stable(step_idx))
      else $error("hold left without event");
   // Event taken while a step is held
   sequence s_hold_release;
      state_r == SSC_HOLD && jump_event;
   endsequence
   a_hold_release: assert property (@(posedge clock) disable iff (srst)
      s_hold_release |=> state_r != SSC_HOLD)
      else $error("held step not released");
   a_step_loops: assert property (@(posedge clock) disable iff (srst)
      state_r == SSC_PLAY && seq_done && step_loop_r < step_entry.loops
      |=> $stable(step_idx))
      else $error("step advanced early");
   a_rep_bound: assert property (@(posedge clock) disable iff (srst)
      state_r != SSC_IDLE |-> rep_r <= once_rdata || $past(once_wr))
      else $error("table repeated too often");
endmodule

// ---- dv/ssc_table_model.sv ----
// Step table and waveform player model for the sequencer control.
// Assumes the table answers step_idx at once and replays last three cycles.
`timescale 1ns/1ps
module ssc_table_model
   import ssc_pkg::*;
(
   input wire logic clock,
   input wire logic playing,
   input wire logic [SSC_STEP_W-1:0] step_idx,
   output ssc_step_type step_entry,
   output logic seq_done
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   // Step 2 loops twice, step 3 waits for an event
   always_comb
   begin
      step_entry.loops = (step_idx == 10'h002) ? 20'h0_0002 : 20'h0_0001;
      step_entry.seq_num = step_idx + 10'h010;
      step_entry.jump_flag = (step_idx == 10'h003);
      cnt_nxt = (!playing || cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
   end
   // Replay timer, restarts when idle
   always_ff @(posedge clock)
      cnt_r <= cnt_nxt;
   assign seq_done = playing && cnt_r == 2'h2;
endmodule

// ---- dv/ssc_seq_ctrl_test.sv ----
// Testbench for the sequencer control: settings, readback and two table runs.
// Assumes the table model beside it and the package in src/.
`timescale 1ns/1ps
module ssc_seq_ctrl_test;
   import ssc_pkg::*;
   logic clock = 1'b0, srst = 1'b1, start = 1'b0, once_wr = 1'b0, sync_wr = 1'b0;
   logic jump_event = 1'b0, seq_done, playing, sync_out, play_q;
   logic [SSC_LOOP_W-1:0] once_wdata = '0, once_rdata;
   logic [SSC_STEP_W-1:0] sync_wdata = '0, step_idx, sync_rdata;
   logic [SSC_SEQ_W-1:0] seq_sel;
   logic [SSC_STEP_W-1:0] step_q;
   ssc_step_type step_entry;
   logic [31:0] rnd = 32'h0000_13a4, rd_q, exp_q[$];
   int fails = 0, n_compared = 0, sync_cnt = 0;
   always #25 clock = ~clock;
   ssc_seq_ctrl ssc_seq_ctrl_i (.clock(clock), .srst(srst), .start(start),
      .once_wr(once_wr), .once_wdata(once_wdata), .sync_wr(sync_wr), .sync_wdata(sync_wdata),
      .table_len(10'h003), .step_entry(step_entry), .seq_done(seq_done),
      .jump_event(jump_event), .step_idx(step_idx), .seq_sel(seq_sel), .playing(playing),
      .sync_out(sync_out), .once_rdata(once_rdata), .sync_rdata(sync_rdata));
   ssc_table_model ssc_table_model_i (.clock(clock), .playing(playing), .step_idx(step_idx),
      .step_entry(step_entry), .seq_done(seq_done));
   function automatic logic [31:0] pop();
      return (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffff_ffff;
   endfunction
   // Xorshift step for the random event stream
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      n_compared++;
      if (got !== want)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   // Sync cycle count of one run
   task automatic check_count(input logic [31:0] got, input logic [31:0] want);
      check(got, want);
   endtask
   // Readback of once count and sync placement
   task automatic check_rdbk(input logic [31:0] got, input logic [31:0] want);
      check(got, want);
   endtask
   // Step and sequence selection
   task automatic check_seq(input logic [31:0] got, input logic [31:0] want);
      check(got, want);
   endtask
   task automatic tally_and_finish();
      $display("compared=%0d mismatches=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic s, input logic [SSC_LOOP_W-1:0] v);
      @(posedge clock);
      sync_wr <= s;
      once_wr <= !s;
      once_wdata <= v;
      sync_wdata <= v[SSC_STEP_W-1:0];
      @(posedge clock);
      sync_wr <= 1'b0;
      once_wr <= 1'b0;
   endtask
   task automatic run(input logic [31:0] n);
      exp_q.push_back(n);
      @(posedge clock);
      start <= 1'b1;
      repeat (2) @(posedge clock);
      start <= 1'b0;
      while (exp_q.size() != 0)
         @(posedge clock);
   endtask
   // Xorshift events release the held step
   always @(posedge clock)
   begin
      rnd <= xorshift(rnd);
      jump_event <= (rnd[1:0] == 2'h0);
   end
   // Monitor: sync cycles per run, step and sequence selection, readback changes
   always @(posedge clock)
   begin
      if (sync_out === 1'b1)
         sync_cnt++;
      if (play_q === 1'b1)
         check_seq({22'h0, seq_sel}, {22'h0, step_q + 10'h010});
      if (play_q === 1'b0 && playing === 1'b1)
         check_seq({22'h0, step_idx}, {22'h0, SSC_STEP_FIRST});
      if (play_q === 1'b1 && playing === 1'b0)
      begin
         check_count(sync_cnt, pop());
         sync_cnt = 0;
      end
      if (srst === 1'b0 && {2'h0, once_rdata, sync_rdata} !== rd_q)
         check_rdbk({2'h0, once_rdata, sync_rdata}, pop());
      play_q = playing;
      step_q = step_idx;
      rd_q = {2'h0, once_rdata, sync_rdata};
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      check_rdbk({2'h0, once_rdata, sync_rdata}, {2'h0, SSC_ONCE_DEF, SSC_SYNC_DEF});
      wr(1'b0, 20'h0_0000);
      exp_q.push_back({2'h0, 20'h0_0002, 10'h001});
      wr(1'b0, 20'h0_0002);
      wr(1'b1, 20'h0_03e9);
      wr(1'b1, 20'h0_0000);
      exp_q.push_back({2'h0, 20'h0_0002, 10'h3e8});
      wr(1'b1, 20'h0_03e8);
      exp_q.push_back({2'h0, 20'h0_0002, 10'h002});
      wr(1'b1, 20'h0_0002);
      run(32'h0000_000c);
      exp_q.push_back({2'h0, 20'h0_0001, 10'h002});
      wr(1'b0, 20'h0_0001);
      exp_q.push_back({2'h0, 20'h0_0001, 10'h001});
      wr(1'b1, 20'h0_0001);
      run(32'h0000_0003);
      tally_and_finish();
   end
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge clock);
      fails++;
      tally_and_finish();
   end
endmodule
